// File: bench/rcic_src.sv
// partner: reset pin, supply monitor and watchdog sources
`timescale 1ns/100ps
module rcic_src (
  input wire logic [1:0] i_kind,
  input wire logic i_go,
  output logic o_por,
  output logic o_pin_n,
  output logic o_lvr,
  output logic o_wdt
);
  // one source at a time, so cause priority never hides a result
  assign o_por = i_go && i_kind == 2'h0;
  assign o_pin_n = !(i_go && i_kind == 2'h1);
  assign o_lvr = i_go && i_kind == 2'h2;
  assign o_wdt = i_go && i_kind == 2'h3;
endmodule

// File: bench/rcic_top_chk.sv
// checker: reset cause assertions on the top ports
`timescale 1ns/100ps
module rcic_top_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_por,
  input wire logic i_external_reset_pin_n,
  input wire logic i_low_voltage_reset,
  input wire logic i_watchdog_timeout,
  input wire logic [1:0] i_mode,
  input wire logic i_halt_set_pdf,
  input wire logic i_clr_wdt_flags,
  input wire logic o_timeout_flag,
  input wire logic o_powerdown_flag,
  input wire logic o_pc_clear,
  input wire logic o_sp_clear,
  input wire logic [7:0] o_program_counter_low_byte,
  input wire logic o_ctrl_load_defaults,
  input wire logic o_int_disable,
  input wire logic o_watchdog_timer_clear,
  input wire logic o_timers_off,
  input wire logic o_port_load,
  input wire logic [rcic_pkg::SP_W-1:0] o_sp_value,
  input wire logic [rcic_pkg::PORT_W-1:0] o_port_dir,
  input wire logic [rcic_pkg::PORT_W-1:0] o_port_data
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire quiet = !i_por && i_external_reset_pin_n && !i_low_voltage_reset;
  sequence wdt_idle_s;
    quiet && i_mode[1] && $rose(i_watchdog_timeout);
  endsequence
  sequence wdt_norm_s;
    quiet && !i_mode[1] && $rose(i_watchdog_timeout);
  endsequence
  por_flags_a: assert property (i_por [*5] |->
    !o_timeout_flag && !o_powerdown_flag) else $error("por flags");
  por_init_a: assert property (i_por [*5] |->
    o_int_disable && o_timers_off && o_sp_clear && o_port_data == 8'hFF
    && o_port_load && o_port_dir == 8'hFF && o_sp_value == 3'h0)
    else $error("por init");
  por_run_a: assert property (i_por [*5] ##1 !i_por |->
    o_watchdog_timer_clear ##[1:5] !o_watchdog_timer_clear)
    else $error("wdt clear");
  flag_hold_a: assert property ((!i_por && !i_watchdog_timeout &&
    !i_halt_set_pdf && !i_clr_wdt_flags) [*5] |-> $stable(o_timeout_flag)
    && $stable(o_powerdown_flag)) else $error("flags moved");
  wdt_norm_a: assert property (wdt_norm_s |->
    ##[2:4] o_timeout_flag && o_ctrl_load_defaults) else $error("wdt");
  wdt_idle_a: assert property (wdt_idle_s |->
    ##[2:4] o_pc_clear && o_sp_clear && o_timeout_flag && o_powerdown_flag)
    else $error("wake");
  idle_keep_a: assert property (wdt_idle_s |->
    !o_ctrl_load_defaults [*5]) else $error("wake defaults");
  pin_pc_a: assert property (!i_external_reset_pin_n [*5] |->
    o_pc_clear && o_program_counter_low_byte == 8'h00) else $error("pc");
endmodule
bind rcic_top rcic_top_chk i_rcic_top_chk (.*);

// File: bench/tb_rcic_top.sv
// testbench: reset causes, flags and start-up delays
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb_rcic_top;
  logic clk = 0, rstn = 0, go = 0, hlt = 0, clr = 0;
  logic [1:0] kind = 0, mode = 0;
  logic [2:0] osc = 0;
  logic por, pin_n, low_voltage_reset, wdt, to, powerdown_flag, hold;
  int errors = 0, checks = 0, cyc = 0, n;
  always #5 clk = ~clk;
  rcic_src i_rcic_src (.i_kind(kind), .i_go(go), .o_por(por),
    .o_pin_n(pin_n), .o_lvr(low_voltage_reset), .o_wdt(wdt));
  rcic_top i_rcic_top (.i_sys_clk(clk), .i_rstn(rstn), .i_por(por),
    .i_external_reset_pin_n(pin_n), .i_low_voltage_reset(low_voltage_reset),
    .i_watchdog_timeout(wdt), .i_mode(mode), .i_osc_sel(osc),
    .i_halt_set_pdf(hlt), .i_clr_wdt_flags(clr), .o_timeout_flag(to),
    .o_powerdown_flag(powerdown_flag), .o_pc_clear(), .o_sp_clear(), .o_sp_value(),
    .o_program_counter_low_byte(), .o_ctrl_load_defaults(),
    .o_int_disable(), .o_watchdog_timer_clear(), .o_timers_off(),
    .o_port_load(), .o_port_data(), .o_port_dir(), .o_exec_hold(hold));
  task automatic fire(input logic [1:0] k, input int len);
    kind <= k;
    go <= 1;
    repeat (len) @(posedge clk);
    go <= 0;
    repeat (12) @(posedge clk);
  endtask
  // h=1 halt entry, h=0 watchdog clear instruction
  task automatic tick(input bit h);
    hlt <= h;
    clr <= !h;
    @(posedge clk);
    hlt <= 0;
    clr <= 0;
    repeat (4) @(posedge clk);
  endtask
  // lower bound of the hold; codes 5-7 behave as crystal
  function automatic int dly(input int s);
    return s == 4 ? 1 : s < 2 ? 15 : 1024;
  endfunction
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(96));
    repeat (20) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    tick(1);
    fire(2'h0, 6);
    `CHK("to", 1'b0, to)
    `CHK("pdf", 1'b0, powerdown_flag)
    mode <= 2'($urandom % 2);
    tick(1);
    fire(2'h3, 3);
    `CHK("to", 1'b1, to)
    `CHK("pdf", 1'b1, powerdown_flag)
    fire(2'h1, 5);
    `CHK("to", 1'b1, to)
    `CHK("pdf", 1'b1, powerdown_flag)
    tick(0);
    fire(2'h2, 5);
    `CHK("to", 1'b0, to)
    for (int s = 0; s < 8; s++) begin
      osc <= 3'(s);
      mode <= 2'(2 + $urandom % 2);
      tick(0);
      kind <= 2'h3;
      go <= 1;
      n = 0;
      repeat (1100) begin
        @(posedge clk);
        #1 n += int'(hold === 1'b1);
      end
      `CHK("hold", 1'b1, n inside {[dly(s):dly(s) + 1]})
      `CHK("to", 1'b1, to)
      `CHK("pdf", 1'b1, powerdown_flag)
      @(posedge clk);
      go <= 0;
    end
    stop_test();
  end
endmodule

// File: verilog/rcic_delay_if.sv
// interface: start-up delay request and status
`timescale 1ns/100ps
interface rcic_delay_if;
  logic start;
  logic [rcic_pkg::DLY_W-1:0] cycles;
  logic busy;
  modport ctrl (output start, output cycles, input busy);
  modport timer (input start, input cycles, output busy);
endinterface

// File: verilog/rcic_pkg.sv
// package: constants and types for the reset cause and init control block
package rcic_pkg;
  localparam int PC_W = 13;
  localparam int SP_W = 3;
  localparam int PORT_W = 8;
  localparam int DLY_W = 11;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [PORT_W-1:0] PORT_RESET = 8'hFF;
  localparam logic [7:0] PCL_RESET = 8'h00;
  // start-up delays in clock cycles, per oscillator family
  localparam int SST_RC_FAST_CYC = 16;
  localparam int SST_XTAL_CYC = 1024;
  localparam int SST_RC_SLOW_CYC = 2;
  // oscillator select codes
  localparam logic [2:0] OSC_EXT_RC = 3'h0;
  localparam logic [2:0] OSC_FAST_RC = 3'h1;
  localparam logic [2:0] OSC_FAST_XTAL = 3'h2;
  localparam logic [2:0] OSC_SLOW_XTAL = 3'h3;
  localparam logic [2:0] OSC_SLOW_RC = 3'h4;
  typedef enum logic [1:0] {
    RCIC_MODE_NORMAL,
    RCIC_MODE_SLOW,
    RCIC_MODE_IDLE,
    RCIC_MODE_SLEEP
  } rcic_mode_t;
endpackage

// File: verilog/rcic_startup_timer.sv
// module: start-up delay down counter
`timescale 1ns/100ps
module rcic_startup_timer (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  rcic_delay_if.timer dly
);
  logic [rcic_pkg::DLY_W-1:0] cnt_q;
  logic [rcic_pkg::DLY_W-1:0] cnt_d;
  wire running = (cnt_q != '0);
  assign cnt_d = dly.start ? dly.cycles :
                 running ? cnt_q - 1'b1 : cnt_q;
  assign dly.busy = running;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule

// File: verilog/rcic_top.sv
// module: reset cause recording and init state control
`timescale 1ns/100ps
module rcic_top (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_por,
  input wire logic i_external_reset_pin_n,
  input wire logic i_low_voltage_reset,
  input wire logic i_watchdog_timeout,
  input wire logic [1:0] i_mode,
  input wire logic [2:0] i_osc_sel,
  input wire logic i_halt_set_pdf,
  input wire logic i_clr_wdt_flags,
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic o_pc_clear,
  output logic o_sp_clear,
  output logic [rcic_pkg::SP_W-1:0] o_sp_value,
  output logic [7:0] o_program_counter_low_byte,
  output logic o_ctrl_load_defaults,
  output logic o_int_disable,
  output logic o_watchdog_timer_clear,
  output logic o_timers_off,
  output logic o_port_load,
  output logic [rcic_pkg::PORT_W-1:0] o_port_data,
  output logic [rcic_pkg::PORT_W-1:0] o_port_dir,
  output logic o_exec_hold
);
  // async sources pass a two-stage synchroniser before use
  logic [1:0] por_s_q;
  logic [1:0] pin_s_q;
  logic [1:0] lvr_s_q;
  logic [1:0] wdt_s_q;
  logic wdt_prev_q;
  logic to_q;
  logic to_d;
  logic pdf_q;
  logic pdf_d;
  logic [7:0] pcl_q;
  logic full_q;
  logic sp_clr_q;
  logic [rcic_pkg::SP_W-1:0] sp_q;
  logic [rcic_pkg::PORT_W-1:0] port_data_q;
  logic [rcic_pkg::PORT_W-1:0] port_dir_q;
  logic pc_clr_q;
  logic [rcic_pkg::DLY_W-1:0] sst_cyc;

  rcic_delay_if dif ();

  wire por_act = por_s_q[1];
  // pin is active low; its synchroniser resets to the idle high level
  wire pin_act = ~pin_s_q[1];
  wire lvr_act = lvr_s_q[1];
  // watchdog is an event: take its rising edge only
  wire wdt_ev = wdt_s_q[1] & ~wdt_prev_q;
  // mode comes from the core on this clock, so no synchroniser
  rcic_pkg::rcic_mode_t mode;
  assign mode = rcic_pkg::rcic_mode_t'(i_mode);
  wire low_power = (mode == rcic_pkg::RCIC_MODE_IDLE) |
                   (mode == rcic_pkg::RCIC_MODE_SLEEP);
  // a level source outranks the watchdog, so causes stay exclusive
  wire src_quiet = ~por_act & ~pin_act & ~lvr_act;
  wire wdt_wake = wdt_ev & low_power & src_quiet;
  wire wdt_norm = wdt_ev & ~low_power & src_quiet;
  // an idle or sleep wake is no full reset: control state survives it
  wire full_rst = por_act | pin_act | lvr_act | wdt_norm;

  // every cause that restarts fetch from address zero
  wire pc_restart = full_rst | wdt_wake;

  // each length is the upper end of its range
  function automatic logic [rcic_pkg::DLY_W-1:0] sst_len(
    input logic [2:0] sel);
    logic [rcic_pkg::DLY_W-1:0] r;
    r = rcic_pkg::DLY_W'(rcic_pkg::SST_RC_FAST_CYC);
    unique case (sel)
      rcic_pkg::OSC_EXT_RC, rcic_pkg::OSC_FAST_RC:
        r = rcic_pkg::DLY_W'(rcic_pkg::SST_RC_FAST_CYC);
      rcic_pkg::OSC_FAST_XTAL, rcic_pkg::OSC_SLOW_XTAL:
        r = rcic_pkg::DLY_W'(rcic_pkg::SST_XTAL_CYC);
      rcic_pkg::OSC_SLOW_RC:
        r = rcic_pkg::DLY_W'(rcic_pkg::SST_RC_SLOW_CYC);
      default: r = rcic_pkg::DLY_W'(rcic_pkg::SST_XTAL_CYC);
    endcase
    return r;
  endfunction

  assign sst_cyc = sst_len(i_osc_sel);
  assign dif.start = wdt_wake;
  // the wake cycle itself is the first delay cycle, so load one less
  assign dif.cycles = sst_cyc - rcic_pkg::DLY_W'(1);

  // the counter runs only after a wake, never after a full reset
  rcic_startup_timer u_sst (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .dly(dif)
  );

  // flag next state; reset events win over software clears, except on pdf at a normal-mode watchdog reset
  always_comb begin
    to_d = to_q;
    pdf_d = pdf_q;
    if (i_clr_wdt_flags) begin
      to_d = 1'b0;
      pdf_d = 1'b0;
    end
    if (i_halt_set_pdf) pdf_d = 1'b1;
    if (por_act) begin
      to_d = 1'b0;
      pdf_d = 1'b0;
    end else if (pin_act | lvr_act) begin
      to_d = to_q;
      pdf_d = pdf_q;
    end else if (wdt_norm) begin
      to_d = 1'b1;
    end else if (wdt_wake) begin
      to_d = 1'b1;
      pdf_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      por_s_q <= 2'h0;
      pin_s_q <= 2'h3;
      lvr_s_q <= 2'h0;
      wdt_s_q <= 2'h0;
      wdt_prev_q <= 1'b0;
    end else begin
      por_s_q <= {por_s_q[0], i_por};
      pin_s_q <= {pin_s_q[0], i_external_reset_pin_n};
      lvr_s_q <= {lvr_s_q[0], i_low_voltage_reset};
      wdt_s_q <= {wdt_s_q[0], i_watchdog_timeout};
      wdt_prev_q <= wdt_s_q[1];
    end
  end

  // i_rstn acts as the chip's power-on: flags start cleared
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      to_q <= 1'b0;
      pdf_q <= 1'b0;
      full_q <= 1'b1;
      pc_clr_q <= 1'b1;
      sp_clr_q <= 1'b1;
    end else begin
      to_q <= to_d;
      pdf_q <= pdf_d;
      // a level source keeps these high until it drops
      full_q <= full_rst;
      pc_clr_q <= pc_restart;
      sp_clr_q <= pc_restart;
    end
  end

  // no write path here: the core owns pcl between resets
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) pcl_q <= rcic_pkg::PCL_RESET;
    else if (pc_restart) pcl_q <= rcic_pkg::PCL_RESET;
  end

  // reset images kept in flops so every data output leaves a register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      port_data_q <= rcic_pkg::PORT_RESET;
      port_dir_q <= rcic_pkg::PORT_RESET;
      sp_q <= rcic_pkg::SP_RESET;
    end else begin
      if (full_rst) begin
        port_data_q <= rcic_pkg::PORT_RESET;
        port_dir_q <= rcic_pkg::PORT_RESET;
      end
      if (pc_restart) sp_q <= rcic_pkg::SP_RESET;
    end
  end

  // start-up hold: the wake cycle itself, then the counter's run
  wire sst_hold = dif.busy | dif.start;
  // reset-stage hold: a full reset or the cleared pc still standing
  wire rst_hold = full_q | pc_clr_q;

  // reset-cause flags
  assign o_timeout_flag = to_q;
  assign o_powerdown_flag = pdf_q;

  // core restart
  assign o_pc_clear = pc_clr_q;
  assign o_sp_clear = sp_clr_q;
  // top of stack: pointer value zero, the entry the next push fills
  assign o_sp_value = sp_q;
  assign o_program_counter_low_byte = pcl_q;

  // peripheral defaults, only on full resets
  assign o_ctrl_load_defaults = full_q;
  assign o_int_disable = full_q;
  // clear follows full_q, so it stays high while a level source stands and the watchdog counts again once it drops
  assign o_watchdog_timer_clear = full_q;
  assign o_timers_off = full_q;
  assign o_port_load = full_q;
  assign o_port_data = port_data_q;
  assign o_port_dir = port_dir_q;

  // hold while any reset source stands or the start-up delay runs
  assign o_exec_hold = rst_hold | sst_hold;
endmodule
